// *** rtl/sdtc_top.v ***
// Strobed 32-line digital I/O transfer control with AXI4-Lite registers.
// Assumes pins are asynchronous to CLK_I; DMA ports face a bus bridge.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`include "sdtc_defines.vh"
module sdtc_top (
  // Clock and reset
  input wire CLK_I,
  input wire RST_B_I,
  // AXI4-Lite slave
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output wire ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  // Port lines
  input wire [15:0] FIRST_PORT_I,
  output reg [15:0] FIRST_PORT_O,
  output reg [15:0] FIRST_PORT_OE_O,
  input wire [15:0] SECOND_PORT_I,
  output reg [15:0] SECOND_PORT_O,
  output reg [15:0] SECOND_PORT_OE_O,
  // Control lines
  input wire IN_STROBE_PIN_I,
  output reg IN_ACK_PIN_O,
  input wire IN_TRIGGER_PIN_I,
  output reg OUT_STROBE_PIN_O,
  input wire OUT_ACK_PIN_I,
  input wire OUT_TRIGGER_PIN_I,
  // DMA towards host memory
  output wire [31:0] DMA_IN_DATA_O,
  output wire DMA_IN_VALID_O,
  input wire DMA_IN_READY_I,
  input wire [31:0] DMA_OUT_DATA_I,
  input wire DMA_OUT_VALID_I,
  output wire DMA_OUT_READY_O
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ARM = 2'd1;
  localparam ST_RUN = 2'd2;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [1:0] in_clk_sel_reg;
  reg in_hs_reg;
  reg in_imm_reg;
  reg in_en_reg;
  reg in_clr_reg;
  reg input_overrun_flag_reg;
  reg [1:0] out_mode_reg;
  reg pat_reg;
  reg out_imm_reg;
  reg out_en_reg;
  reg out_clr_reg;
  reg out_under_reg;
  reg [2:0] width_reg;
  reg [15:0] timer_div_reg [0:1];
  reg [5:0] control_line_polarity_reg;
  wire [5:0] pol = control_line_polarity_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  reg [35:0] sync1_reg;
  reg [35:0] sync2_reg;
  reg [3:0] act_prev_reg;
  wire [3:0] act = sync2_reg[35:32] ^ {pol[`SDTC_POL_OUT_TRIG], pol[`SDTC_POL_OUT_ACK],
                   pol[`SDTC_POL_IN_TRIG], pol[`SDTC_POL_IN_STROBE]};
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sync1_reg <= 36'h0;
      sync2_reg <= 36'h0;
      act_prev_reg <= 4'h0;
    end else begin
      sync1_reg <= {OUT_TRIGGER_PIN_I, OUT_ACK_PIN_I, IN_TRIGGER_PIN_I,
                    IN_STROBE_PIN_I, SECOND_PORT_I, FIRST_PORT_I};
      sync2_reg <= sync1_reg;
      act_prev_reg <= act;
    end
  end
  wire [3:0] edge_on = act & ~act_prev_reg;
  wire in_side_ok = (width_reg != `SDTC_WIDE_OUT);
  wire out_side_ok = (width_reg != `SDTC_WIDE_IN);
  wire in_strobe_edge = edge_on[0] & in_side_ok;
  wire in_trig_edge = edge_on[1] & in_side_ok;
  wire out_ack_edge = edge_on[2] & out_side_ok;
  wire out_trig_edge = edge_on[3] & out_side_ok;
  wire in8 = (width_reg == `SDTC_SPLIT_8_16) || (width_reg == `SDTC_SPLIT_8_8);
  wire out8 = (width_reg == `SDTC_SPLIT_16_8) || (width_reg == `SDTC_SPLIT_8_8);
  wire [31:0] in_word = (width_reg == `SDTC_WIDE_IN) ? sync2_reg[31:0] :
                        in8 ? {24'h0, sync2_reg[7:0]} : {16'h0, sync2_reg[15:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Pacers: 20MHz every cycle, 10MHz every other, timers step by two
  reg tog10_reg;
  wire [1:0] timer_tick;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_timer
      reg [16:0] acc_reg;
      wire [15:0] div = (timer_div_reg[gi] < 16'h0002) ? 16'h0002 : timer_div_reg[gi];
      wire [31:0] step = `SDTC_TIMER_STEP;
      wire [16:0] sum = acc_reg + step[16:0];
      assign timer_tick[gi] = (sum >= {1'b0, div});
      always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          acc_reg <= 17'h0;
        end else begin
          acc_reg <= timer_tick[gi] ? sum - {1'b0, div} : sum;
        end
      end
    end
  endgenerate
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tog10_reg <= 1'b0;
    end else begin
      tog10_reg <= ~tog10_reg;
    end
  end
  function pace;
    input [1:0] sel;
    input t;
    input t10;
    begin
      case (sel)
        `SDTC_CLK_TIMER: pace = t;
        `SDTC_CLK_20M: pace = 1'b1;
        `SDTC_CLK_10M: pace = t10;
        default: pace = 1'b0;
      endcase
    end
  endfunction
  wire in_tick = pace(in_clk_sel_reg, timer_tick[0], tog10_reg);
  wire out_tick = pace(out_mode_reg, timer_tick[1], tog10_reg);

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs, one per direction
  wire ififo_ready;
  wire ififo_valid;
  wire ififo_af;
  wire [31:0] ififo_data;
  wire ofifo_ready;
  wire ofifo_valid;
  wire [31:0] ofifo_data;
  wire in_push;
  wire axi_in_pop;
  wire axi_out_push;
  wire out_pop;
  sdtc_fifo u_in_fifo (
    .clk_i(CLK_I), .rst_b_i(RST_B_I), .clr_i(in_clr_reg), .loop_i(1'b0),
    .almost_full_o(ififo_af), .wr_valid_i(in_push), .wr_data_i(in_word),
    .wr_ready_o(ififo_ready), .rd_valid_o(ififo_valid),
    .rd_ready_i(axi_in_pop | (DMA_IN_VALID_O & DMA_IN_READY_I)),
    .rd_data_o(ififo_data)
  );
  sdtc_fifo u_out_fifo (
    .clk_i(CLK_I), .rst_b_i(RST_B_I), .clr_i(out_clr_reg), .loop_i(pat_reg),
    .almost_full_o(), .wr_valid_i(axi_out_push | DMA_OUT_VALID_I),
    .wr_data_i(axi_out_push ? WDATA : DMA_OUT_DATA_I), .wr_ready_o(ofifo_ready),
    .rd_valid_o(ofifo_valid), .rd_ready_i(out_pop), .rd_data_o(ofifo_data)
  );
  // Register accesses take the FIFO ports ahead of DMA in the same cycle
  assign DMA_IN_DATA_O = ififo_data;
  assign DMA_IN_VALID_O = ififo_valid & ~axi_in_pop;
  assign DMA_OUT_READY_O = ofifo_ready & ~axi_out_push;

  ////////////////////////////////////////////////////////////////////////////
  // Input transfer
  reg [1:0] in_st_reg;
  reg in_hs_ack_reg;
  wire in_run = (in_st_reg == ST_RUN) & in_en_reg & in_side_ok;
  wire in_ext = (in_clk_sel_reg == `SDTC_CLK_EXT);
  wire in_event = in_run & ((in_hs_reg | in_ext) ? in_strobe_edge & ~in_hs_ack_reg
                  : in_tick);
  assign in_push = in_event;
  wire over_set = in_event & ~ififo_ready;
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      in_st_reg <= ST_IDLE;
      in_hs_ack_reg <= 1'b0;
      IN_ACK_PIN_O <= 1'b0;
    end else begin
      case (in_st_reg)
        ST_IDLE: begin
          if (in_en_reg) begin
            in_st_reg <= in_imm_reg ? ST_RUN : ST_ARM;
          end
        end
        ST_ARM: begin
          if (!in_en_reg) begin
            in_st_reg <= ST_IDLE;
          end else if (in_trig_edge) begin
            in_st_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!in_en_reg) begin
            in_st_reg <= ST_IDLE;
          end
        end
        default: in_st_reg <= ST_IDLE;
      endcase
      if (in_hs_reg & in_event) begin
        in_hs_ack_reg <= 1'b1;
      end else if (!act[0] || !in_run) begin
        in_hs_ack_reg <= 1'b0;
      end
      IN_ACK_PIN_O <= pol[`SDTC_POL_IN_ACK] ^ (in_side_ok & (in_hs_reg ? in_hs_ack_reg :
                      in_ext & in_en_reg & ~ififo_af));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output transfer
  reg [1:0] out_st_reg;
  reg [31:0] out_word_reg;
  reg out_req_reg;
  reg out_pend_reg;
  reg out_pulse_reg;
  wire out_run = (out_st_reg == ST_RUN) & out_en_reg & out_side_ok;
  wire out_hs = (out_mode_reg == `SDTC_CLK_EXT);
  wire out_load = out_run & ofifo_valid &
                  (out_hs ? ~out_req_reg & ~out_pend_reg : out_tick);
  assign out_pop = out_load;
  wire under_set = out_run & ~out_hs & out_tick & ~ofifo_valid;
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      out_st_reg <= ST_IDLE;
      out_word_reg <= 32'h0;
      out_req_reg <= 1'b0;
      out_pend_reg <= 1'b0;
      out_pulse_reg <= 1'b0;
      OUT_STROBE_PIN_O <= 1'b0;
    end else begin
      case (out_st_reg)
        ST_IDLE: begin
          if (out_en_reg) begin
            out_st_reg <= out_imm_reg ? ST_RUN : ST_ARM;
          end
        end
        ST_ARM: begin
          if (!out_en_reg) begin
            out_st_reg <= ST_IDLE;
          end else if (out_trig_edge) begin
            out_st_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!out_en_reg) begin
            out_st_reg <= ST_IDLE;
          end
        end
        default: out_st_reg <= ST_IDLE;
      endcase
      if (out_load) begin
        out_word_reg <= ofifo_data;
      end
      // Request follows the data by a cycle so the peripheral sees settled lines
      out_pend_reg <= out_load & out_hs;
      if (out_pend_reg) begin
        out_req_reg <= 1'b1;
      end else if (out_ack_edge || !out_run) begin
        out_req_reg <= 1'b0;
      end
      out_pulse_reg <= out_load & ~out_hs;
      OUT_STROBE_PIN_O <= pol[`SDTC_POL_OUT_STROBE] ^
                          (out_side_ok & (out_hs ? out_req_reg : out_pulse_reg));
    end
  end
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      FIRST_PORT_O <= 16'h0000;
      FIRST_PORT_OE_O <= 16'h0000;
      SECOND_PORT_O <= 16'h0000;
      SECOND_PORT_OE_O <= 16'h0000;
    end else begin
      FIRST_PORT_O <= (width_reg == `SDTC_WIDE_OUT) ? out_word_reg[31:16] : 16'h0000;
      FIRST_PORT_OE_O <= (width_reg == `SDTC_WIDE_OUT) ? 16'hFFFF : 16'h0000;
      SECOND_PORT_O <= out8 ? {8'h00, out_word_reg[7:0]} : out_word_reg[15:0];
      SECOND_PORT_OE_O <= !out_side_ok ? 16'h0000 : out8 ? 16'h00FF : 16'hFFFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: write when address and data are both present
  wire wr_go = AWVALID & WVALID & ~BVALID;
  assign AWREADY = wr_go;
  assign WREADY = wr_go;
  assign ARREADY = ~RVALID;
  wire rd_go = ARVALID & ~RVALID;
  wire [7:0] wa = AWADDR & 8'hFC;
  wire [7:0] ra = ARADDR & 8'hFC;
  wire wr_full = (WSTRB == 4'hF);
  assign axi_out_push = wr_go & wr_full & (wa == `SDTC_OUT_FIFO_OFS) & ofifo_ready;
  assign axi_in_pop = rd_go & (ra == `SDTC_IN_FIFO_OFS) & ififo_valid;
  wire wr_in = wr_go & WSTRB[0] & (wa == `SDTC_IN_CTRL_OFS);
  wire wr_out = wr_go & WSTRB[0] & (wa == `SDTC_OUT_CTRL_OFS);
  wire wr_map = (wa == `SDTC_IN_CTRL_OFS) || (wa == `SDTC_OUT_CTRL_OFS) ||
                (wa == `SDTC_WIDTH_OFS) || (wa == `SDTC_TIMER_OFS) ||
                (wa == `SDTC_IN_FIFO_OFS) || (wa == `SDTC_OUT_FIFO_OFS) ||
                (wa == `SDTC_POL_OFS);
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      in_clk_sel_reg <= `SDTC_CLK_TIMER;
      in_hs_reg <= 1'b0;
      in_imm_reg <= 1'b0;
      in_en_reg <= 1'b0;
      in_clr_reg <= 1'b0;
      input_overrun_flag_reg <= 1'b0;
      out_mode_reg <= `SDTC_CLK_TIMER;
      pat_reg <= 1'b0;
      out_imm_reg <= 1'b0;
      out_en_reg <= 1'b0;
      out_clr_reg <= 1'b0;
      out_under_reg <= 1'b0;
      width_reg <= `SDTC_SPLIT_16_16;
      timer_div_reg[0] <= `SDTC_TIMER_RESET;
      timer_div_reg[1] <= `SDTC_TIMER_RESET;
      control_line_polarity_reg <= `SDTC_POL_RESET;
      BVALID <= 1'b0;
      BRESP <= `SDTC_RESP_OKAY;
    end else begin
      in_clr_reg <= wr_in & WDATA[`SDTC_CLR_BIT];
      out_clr_reg <= wr_out & WDATA[`SDTC_CLR_BIT];
      if (wr_in) begin
        in_clk_sel_reg <= WDATA[`SDTC_CLK_LSB+1:`SDTC_CLK_LSB];
        in_hs_reg <= WDATA[`SDTC_HS_BIT];
        in_imm_reg <= WDATA[`SDTC_IMM_BIT];
        in_en_reg <= WDATA[`SDTC_EN_BIT];
      end
      if (wr_out) begin
        out_mode_reg <= WDATA[`SDTC_CLK_LSB+1:`SDTC_CLK_LSB];
        pat_reg <= WDATA[`SDTC_HS_BIT];
        out_imm_reg <= WDATA[`SDTC_IMM_BIT];
        out_en_reg <= WDATA[`SDTC_EN_BIT];
      end
      // Hardware set wins over a write-one clear in the same cycle
      input_overrun_flag_reg <= over_set | (input_overrun_flag_reg &
                                ~(wr_in & WDATA[`SDTC_FLAG_BIT]));
      out_under_reg <= under_set | (out_under_reg & ~(wr_out & WDATA[`SDTC_FLAG_BIT]));
      if (wr_go & WSTRB[0] & (wa == `SDTC_WIDTH_OFS)) begin
        width_reg <= WDATA[2:0];
      end
      if (wr_go & (wa == `SDTC_TIMER_OFS)) begin
        if (WSTRB[0]) timer_div_reg[0][7:0] <= WDATA[7:0];
        if (WSTRB[1]) timer_div_reg[0][15:8] <= WDATA[15:8];
        if (WSTRB[2]) timer_div_reg[1][7:0] <= WDATA[23:16];
        if (WSTRB[3]) timer_div_reg[1][15:8] <= WDATA[31:24];
      end
      if (wr_go & WSTRB[0] & (wa == `SDTC_POL_OFS)) begin
        control_line_polarity_reg <= WDATA[5:0];
      end
      if (wr_go) begin
        BVALID <= 1'b1;
        BRESP <= wr_map ? `SDTC_RESP_OKAY : `SDTC_RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end
  // Read answer one cycle after the address is taken
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= `SDTC_RESP_OKAY;
    end else if (rd_go) begin
      RVALID <= 1'b1;
      RRESP <= `SDTC_RESP_OKAY;
      case (ra)
        `SDTC_IN_CTRL_OFS: RDATA <= {23'h0, ~ififo_valid, ~ififo_ready,
          input_overrun_flag_reg, 1'b0, in_en_reg, in_imm_reg, in_hs_reg, in_clk_sel_reg};
        `SDTC_OUT_CTRL_OFS: RDATA <= {23'h0, ~ofifo_valid, ~ofifo_ready,
          out_under_reg, 1'b0, out_en_reg, out_imm_reg, pat_reg, out_mode_reg};
        `SDTC_WIDTH_OFS: RDATA <= {29'h0, width_reg};
        `SDTC_TIMER_OFS: RDATA <= {timer_div_reg[1], timer_div_reg[0]};
        `SDTC_IN_FIFO_OFS: RDATA <= ififo_valid ? ififo_data : 32'h0;
        `SDTC_OUT_FIFO_OFS: RDATA <= 32'h0;
        `SDTC_POL_OFS: RDATA <= {26'h0, control_line_polarity_reg};
        default: begin
          RDATA <= 32'h0;
          RRESP <= `SDTC_RESP_SLVERR;
        end
      endcase
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end
endmodule

// *** rtl/sdtc_defines.vh ***
// Constants for the strobed digital I/O transfer control block.
// Assumes inclusion by bare name from the design files only.
`ifndef SDTC_DEFINES_VH
`define SDTC_DEFINES_VH
// Register byte offsets
`define SDTC_IN_CTRL_OFS 8'h00
`define SDTC_OUT_CTRL_OFS 8'h04
`define SDTC_WIDTH_OFS 8'h08
`define SDTC_TIMER_OFS 8'h0C
`define SDTC_IN_FIFO_OFS 8'h10
`define SDTC_OUT_FIFO_OFS 8'h14
`define SDTC_POL_OFS 8'h1C
// Control register fields (input and output share the layout)
`define SDTC_CLK_LSB 0
`define SDTC_HS_BIT 2
`define SDTC_IMM_BIT 3
`define SDTC_EN_BIT 4
`define SDTC_CLR_BIT 5
`define SDTC_FLAG_BIT 6
`define SDTC_FULL_BIT 7
`define SDTC_EMPTY_BIT 8
// Polarity register bits
`define SDTC_POL_IN_STROBE 0
`define SDTC_POL_IN_ACK 1
`define SDTC_POL_IN_TRIG 2
`define SDTC_POL_OUT_STROBE 3
`define SDTC_POL_OUT_ACK 4
`define SDTC_POL_OUT_TRIG 5
`define SDTC_POL_RESET 6'h00
// Data path width modes
`define SDTC_SPLIT_16_16 3'h0
`define SDTC_WIDE_IN 3'h1
`define SDTC_WIDE_OUT 3'h2
`define SDTC_SPLIT_16_8 3'h3
`define SDTC_SPLIT_8_16 3'h4
`define SDTC_SPLIT_8_8 3'h5
// Clock source selections
`define SDTC_CLK_TIMER 2'h0
`define SDTC_CLK_20M 2'h1
`define SDTC_CLK_10M 2'h2
`define SDTC_CLK_EXT 2'h3
// Timer runs as if clocked at the oscillator rate
`define SDTC_OSC_MHZ 40
`define SDTC_SYS_MHZ 20
`define SDTC_TIMER_STEP (`SDTC_OSC_MHZ / `SDTC_SYS_MHZ)
`define SDTC_TIMER_RESET 16'h0028
// FIFO depth: 16K double words per direction
`define SDTC_FIFO_AW 14
`define SDTC_ALMOST_FULL 15'h3FF0
`define SDTC_RESP_OKAY 2'h0
`define SDTC_RESP_SLVERR 2'h2
`endif

// *** rtl/sdtc_fifo.v ***
// Synchronous FIFO with a replay mode for pattern output.
// Assumes one clock; clear and loop come from the same domain.
`timescale 1ns/10ps
`include "sdtc_defines.vh"
module sdtc_fifo #(
  parameter AW = `SDTC_FIFO_AW
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Control
  input wire clr_i,
  input wire loop_i,
  output wire almost_full_o,
  // Fill side
  input wire wr_valid_i,
  input wire [31:0] wr_data_i,
  output wire wr_ready_o,
  // Drain side
  output wire rd_valid_o,
  input wire rd_ready_i,
  output wire [31:0] rd_data_o
);
  reg [31:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW-1:0] loop_ptr_reg;
  reg [AW:0] count_reg;
  wire push = wr_valid_i & wr_ready_o;
  wire pop = rd_ready_i & rd_valid_o;
  wire [AW-1:0] rd_ptr_inc = rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
  assign wr_ready_o = (count_reg != {1'b1, {AW{1'b0}}});
  assign rd_valid_o = (count_reg != {(AW+1){1'b0}});
  assign rd_data_o = mem[rd_ptr_reg];
  assign almost_full_o = (count_reg >= `SDTC_ALMOST_FULL);
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data_i;
    end
  end
  // In replay mode words are read but never consumed
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      loop_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (clr_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      loop_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (!loop_i) begin
        loop_ptr_reg <= pop ? rd_ptr_inc : rd_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= (loop_i && rd_ptr_inc == wr_ptr_reg) ? loop_ptr_reg : rd_ptr_inc;
      end
      if (push && !(pop && !loop_i)) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (!push && pop && !loop_i) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// *** tb/sdtc_checker.sv ***
// Checker for the strobed I/O transfer block: register bus and port enables.
// Assumes it is bound to sdtc_top and sees only its ports.
`timescale 1ns/10ps
module sdtc_checker (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Register bus
  input wire logic AWVALID,
  input wire logic WVALID,
  input wire logic AWREADY,
  input wire logic BVALID,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  // Port enables
  input wire logic [15:0] FIRST_PORT_OE_O,
  input wire logic [15:0] SECOND_PORT_OE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  //////////////////////////////
  AST_AW_TAKE: assert property (AWREADY == (AWVALID && WVALID && !BVALID))
    else $error("write taken without both channels");
  AST_B_NEXT: assert property (AWVALID && WVALID && !BVALID |=> BVALID)
    else $error("write response late");
  AST_R_NEXT: assert property (ARVALID && !RVALID |=> RVALID)
    else $error("read data late");
  AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read data dropped early");
  AST_UNMAPPED: assert property (ARVALID && !RVALID && ARADDR >= 8'h20 |=> RRESP == 2'h2)
    else $error("unmapped read not refused");
  AST_WIDE_OUT: assert property (FIRST_PORT_OE_O != 16'h0 |-> SECOND_PORT_OE_O == 16'hFFFF)
    else $error("first port drives outside wide output");
  AST_WIDE_IN: assert property (SECOND_PORT_OE_O == 16'h0 |-> FIRST_PORT_OE_O == 16'h0)
    else $error("first port drives in wide input");
  AST_SECOND_OE: assert property (SECOND_PORT_OE_O inside {16'h0, 16'h00FF, 16'hFFFF})
    else $error("second port enable width wrong");
endmodule
bind sdtc_top sdtc_checker checker_i (.CLK_I, .RST_B_I, .AWVALID, .WVALID, .AWREADY, .BVALID,
  .ARADDR, .ARVALID, .RDATA, .RRESP, .RVALID, .RREADY, .FIRST_PORT_OE_O, .SECOND_PORT_OE_O);

// *** tb/sdtc_peripheral.sv ***
// Peripheral model driving strobe, trigger and port data lines.
// Assumes the bench calls its tasks; half a link period is 4 cycles.
`timescale 1ns/10ps
module sdtc_peripheral (
  // Clock
  input wire logic clk_i,
  // Towards the block
  output logic strobe_o,
  output logic trig_o,
  output logic [31:0] data_o,
  // From the block
  input wire logic ack_i
);
  initial {strobe_o, trig_o, data_o} = 34'h0;
  //////////////////////////////
  task automatic half;
    repeat (4) @(posedge clk_i);
  endtask
  // Second port is the upper half of the word
  task automatic put(input logic [31:0] w);
    @(posedge clk_i);
    data_o <= w;
  endtask
  task automatic strobe(input logic [31:0] w, input logic fall);
    put(w);
    strobe_o <= fall;
    half;
    strobe_o <= !fall;
    half;
    strobe_o <= fall;
    half;
    data_o <= ~w; // Hold over, so stale data must not look valid
  endtask
  task automatic trig;
    @(posedge clk_i);
    trig_o <= 1'b1;
    half;
    trig_o <= 1'b0;
  endtask
  task automatic hs(input logic [15:0] w, output logic ok);
    int n, m;
    put({16'h0, w});
    strobe_o <= 1'b0;
    half;
    strobe_o <= 1'b1;
    for (n = 0; n < 64 && ack_i !== 1'b1; n++) @(posedge clk_i);
    strobe_o <= 1'b0;
    for (m = 0; m < 64 && ack_i !== 1'b0; m++) @(posedge clk_i);
    data_o <= {16'hFFFF, ~w};
    ok = n < 64 && m < 64;
  endtask
endmodule

// *** tb/testbench.sv ***
// Bench for the strobed I/O transfer block: bus tasks and scenarios.
// Assumes the peripheral model and bound checker are compiled first.
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0;
  logic ar_v = 1'b0, r_rdy = 1'b0, din_rdy = 1'b0, dout_v = 1'b0, ok;
  logic [7:0] aw_a = 8'h0, ar_a = 8'h0;
  logic [31:0] w_d = 32'h0, dout_d = 32'h0, d;
  logic [1:0] resp;
  logic oack = 1'b0;
  wire aw_rdy, w_rdy, b_v, ar_rdy, r_v, ack, stb, trg, din_v, dout_rdy, ostb;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_d, din_d, pd;
  wire [15:0] fo, foe, so, soe;
  int errors = 0, checked = 0, n;
  always #25 clk = ~clk;
  sdtc_peripheral partner (.clk_i(clk), .strobe_o(stb), .trig_o(trg), .data_o(pd), .ack_i(ack));
  sdtc_top dut (.CLK_I(clk), .RST_B_I(rst_b), .AWADDR(aw_a), .AWVALID(aw_v),
    .AWREADY(aw_rdy), .WDATA(w_d), .WSTRB(4'hF), .WVALID(w_v), .WREADY(w_rdy),
    .BRESP(b_resp), .BVALID(b_v), .BREADY(b_rdy), .ARADDR(ar_a), .ARVALID(ar_v),
    .ARREADY(ar_rdy), .RDATA(r_d), .RRESP(r_resp), .RVALID(r_v), .RREADY(r_rdy),
    .FIRST_PORT_I(pd[15:0]), .FIRST_PORT_O(fo), .FIRST_PORT_OE_O(foe),
    .SECOND_PORT_I(pd[31:16]), .SECOND_PORT_O(so), .SECOND_PORT_OE_O(soe),
    .IN_STROBE_PIN_I(stb), .IN_ACK_PIN_O(ack), .IN_TRIGGER_PIN_I(trg),
    .OUT_STROBE_PIN_O(ostb), .OUT_ACK_PIN_I(oack), .OUT_TRIGGER_PIN_I(trg),
    .DMA_IN_DATA_O(din_d), .DMA_IN_VALID_O(din_v), .DMA_IN_READY_I(din_rdy),
    .DMA_OUT_DATA_I(dout_d), .DMA_OUT_VALID_I(dout_v), .DMA_OUT_READY_O(dout_rdy));
  //////////////////////////////
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    aw_a <= a;
    w_d <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    do @(negedge clk); while (!(aw_rdy && w_rdy));
    @(posedge clk);
    aw_v <= 1'b0;
    w_v <= 1'b0;
    do @(negedge clk); while (b_v !== 1'b1);
    resp = b_resp;
    @(posedge clk);
    b_rdy <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    do @(negedge clk); while (ar_rdy !== 1'b1);
    @(posedge clk);
    ar_v <= 1'b0;
    do @(negedge clk); while (r_v !== 1'b1);
    d = r_d;
    resp = r_resp;
    @(posedge clk);
    r_rdy <= 1'b0;
  endtask
  task automatic complete_run;
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Whole run needs about 17000 cycles, most of them filling the input FIFO
  initial begin
    #1500000;
    errors++;
    complete_run;
  end
  //////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h1C);
    chk(d, 32'h0);
    rd(8'h08);
    chk(d, 32'h0);
    chk({foe, soe}, 32'hFFFF);
    wr(8'h1C, 32'h3F);
    rd(8'h1C);
    chk(d, 32'h3F);
    wr(8'h20, 32'h1);
    chk(resp, 32'h2);
    rd(8'h20);
    chk({d[29:0], resp}, 32'h2);
    wr(8'h1C, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h1B);
    repeat (4) @(posedge clk);
    chk({ack, soe}, 17'h10000);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge clk);
    chk(ack, 1'b0);
    wr(8'h1C, 32'h3);
    wr(8'h00, 32'h1B);
    repeat (4) @(posedge clk);
    chk(ack, 1'b0);
    partner.strobe(32'hA5C3_1E78, 1'b1);
    rd(8'h10);
    chk(d, 32'hA5C3_1E78);
    rd(8'h00);
    chk(d, 32'h11B);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h13);
    partner.strobe(32'h0F1E_2D3C, 1'b1);
    rd(8'h10);
    chk(d, 32'h0);
    partner.trig;
    partner.strobe(32'h0F1E_2D3C, 1'b1);
    rd(8'h10);
    chk(d, 32'h0F1E_2D3C);
    wr(8'h08, 32'h0);
    partner.put(32'h3C5A);
    for (n = 0; n < 3; n++) begin
      wr(8'h00, 32'h20);
      wr(8'h00, 32'h18 | n);
      repeat (60) @(posedge clk);
      wr(8'h00, 32'h0);
      rd(8'h10);
      chk(d[15:0], 16'h3C5A);
    end
    wr(8'h1C, 32'h0);
    wr(8'h00, 32'h3C);
    partner.hs(16'h69F0, ok);
    rd(8'h10);
    chk({ok, d[15:0]}, 17'h169F0);
    partner.hs(16'h1234, ok);
    din_rdy <= 1'b1;
    for (n = 0; n < 64 && din_v !== 1'b1; n++) @(negedge clk);
    chk(din_d[15:0], 16'h1234);
    @(posedge clk);
    din_rdy <= 1'b0;
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h19);
    repeat (16500) @(posedge clk);
    rd(8'h00);
    chk(d, 32'hD9);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h60);
    rd(8'h00);
    chk(d, 32'h100);
    wr(8'h08, 32'h2);
    wr(8'h0C, 32'h0028_0028);
    wr(8'h14, 32'h1234_ABCD);
    wr(8'h04, 32'h18);
    for (n = 0; n < 80 && {fo, so} !== 32'h1234_ABCD; n++) @(negedge clk);
    chk({fo, so}, 32'h1234_ABCD);
    chk(foe, 16'hFFFF);
    @(posedge clk);
    dout_d <= 32'h5A5A_0F0F;
    dout_v <= 1'b1;
    do @(negedge clk); while (dout_rdy !== 1'b1);
    @(posedge clk);
    dout_v <= 1'b0;
    dout_d <= 32'hA5A5_F0F0;
    for (n = 0; n < 80 && {fo, so} !== 32'h5A5A_0F0F; n++) @(negedge clk);
    chk({fo, so}, 32'h5A5A_0F0F);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h60);
    wr(8'h14, 32'h1111_2222);
    wr(8'h14, 32'h3333_4444);
    wr(8'h04, 32'h1D);
    for (n = 0; n < 40 && {fo, so} !== 32'h1111_2222; n++) @(negedge clk);
    @(negedge clk);
    chk({fo, so}, 32'h3333_4444);
    @(negedge clk);
    chk({fo, so}, 32'h1111_2222);
    rd(8'h04);
    chk(d, 32'h1D);
    wr(8'h04, 32'h20);
    wr(8'h14, 32'hC3C3_3C3C);
    wr(8'h04, 32'h1B);
    for (n = 0; n < 40 && ostb !== 1'b1; n++) @(negedge clk);
    chk({ostb, fo}, 17'h1C3C3);
    chk(so, 16'h3C3C);
    @(posedge clk);
    oack <= 1'b1;
    for (n = 0; n < 40 && ostb !== 1'b0; n++) @(negedge clk);
    chk(ostb, 1'b0);
    @(posedge clk);
    oack <= 1'b0;
    complete_run;
  end
endmodule
